//--- rtl/iopm_port_mapper.v
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/10ps
`include "iopm_defs.vh"
// Operation
// R1: sixteen ports, inputs 1-8, outputs 9-16, one of five profiles from config
// R2: standard: start, error reset, counter reset, release; outputs error..return
// R3: standard profile ignores inputs 5 to 8
// R4: second standard: ready, cassette open, printing, return, head down, position
// R5: port 16 always shows ribbon prior warning; in service mode the code drives force bit 7 there instead
// R6: file-select: inputs 3-8 are file number bits 0-5
// R7: file number zero loads nothing and keeps existing order
// R8: load taken only in ready, waiting or stop state
// R9: after load, old order deleted and new order started
// R10: number matched against stored one- or two-digit name prefix
// R11: reduced: port 9 ready, 10-12 unused, 13-16 ready/error/return/warning
// R12: legacy: 13 print-ready, 14 head down, input 4 no function
// R13: service mode shows every input level
// R14: service mode forces each output low or high
// R15: ready only when a start pulse can be accepted, layout time included
// R16: return shown after print; start waits for start position; the code drops a start seen away from it or while returning
// R17: outside party drives inputs active high
// R18: file number unsigned, bit 0 least significant, 1 to 63
module iopm_port_mapper (
  // clock and reset
  input wire mclk_i,
  input wire rst_n_i,
  // register port
  input wire [3:0] reg_addr_i,
  input wire [15:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [15:0] reg_rdata_o,
  // opto input ports 1-8, active high
  input wire [7:0] in_port_i,
  // printer status from the controller
  input wire [1:0] prn_state_i,
  input wire st_error_i,
  input wire st_order_i,
  input wire st_generating_i,
  input wire st_printing_i,
  input wire st_ready_i,
  input wire st_returning_i,
  input wire st_at_start_i,
  input wire st_cassette_open_i,
  input wire st_head_down_i,
  input wire st_print_pos_i,
  input wire st_ribbon_warn_i,
  // file directory lookup: file_num prefix match result
  input wire file_found_i,
  // output ports 9-16
  output reg [7:0] out_port_o,
  // function pulses and the file number level toward the controller
  output reg print_start_o,
  output reg error_reset_o,
  output reg counter_reset_o,
  output reg release_o,
  output reg [5:0] file_num_o,
  output reg file_load_o,
  output reg order_delete_o,
  output reg order_start_o,
  // interrupt
  output reg irq_o
);

////////////////////////////////////////////////////////////////////////////////
// input synchroniser

wire [7:0] in_sync; // R17
reg [7:0] in_prev_reg;

// opto levels are asynchronous to mclk_i
iopm_sync u_sync (
  .mclk_i(mclk_i),
  .rst_n_i(rst_n_i),
  .async_i(in_port_i),
  .sync_o(in_sync)
);

// pins idle low, so a cleared history gives no false edge after reset
wire [7:0] in_rise = in_sync & ~in_prev_reg;

////////////////////////////////////////////////////////////////////////////////
// registers

reg [2:0] prof_reg;
reg service_reg;
reg [7:0] force_reg;
reg [`IOPM_IRQ_W-1:0] irq_stat_reg;
reg [`IOPM_IRQ_W-1:0] irq_en_reg;
reg [5:0] loaded_reg;

function is_prof;
  input [2:0] code;
  begin
    is_prof = (code == `IOPM_PROF_STANDARD) || (code == `IOPM_PROF_STANDARD_B) ||
      (code == `IOPM_PROF_FILE_SELECT) || (code == `IOPM_PROF_REDUCED) ||
      (code == `IOPM_PROF_LEGACY);
  end
endfunction

// decode of which input functions the profile carries
function has_release;
  input [2:0] code;
  begin
    has_release = (code == `IOPM_PROF_STANDARD) || (code == `IOPM_PROF_STANDARD_B);
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// input functions

wire file_mode = (prof_reg == `IOPM_PROF_FILE_SELECT);
// unsigned, bit 0 from input port 3
wire [5:0] sel_num = in_sync[7:2]; // R6 R18
reg [5:0] sel_prev_reg;
wire sel_change = file_mode && (sel_num != sel_prev_reg);
wire state_ok = (prn_state_i == `IOPM_PST_READY) ||
  (prn_state_i == `IOPM_PST_WAITING) || (prn_state_i == `IOPM_PST_STOP); // R8
// zero selects nothing and leaves the order alone
wire sel_req = sel_change && (sel_num != 6'h00); // R7
// the lookup answers for file_num_o, which trails the selector by one cycle,
// so a request is decided a cycle later, once the number has held still
reg sel_pend_reg;
wire sel_decide = sel_pend_reg && file_mode && !sel_change;
wire sel_take = sel_decide && state_ok && file_found_i; // R8 R10
wire sel_reject = sel_decide && !sel_take;

// a start while the carriage is still returning is dropped
wire start_ok = st_at_start_i && !st_returning_i; // R16
// service mode mutes every input function
wire ev_start = in_rise[0] && start_ok && !service_reg;
wire ev_err = in_rise[1] && !service_reg;
wire ev_cnt = in_rise[2] && !file_mode && !service_reg; // R3
wire ev_rel = in_rise[3] && has_release(prof_reg) && !service_reg; // R2 R11 R12

always @(posedge mclk_i) begin
  if (!rst_n_i) begin
    in_prev_reg <= 8'h00;
    sel_prev_reg <= 6'h00;
    sel_pend_reg <= 1'b0;
    print_start_o <= 1'b0;
    error_reset_o <= 1'b0;
    counter_reset_o <= 1'b0;
    release_o <= 1'b0;
    file_num_o <= 6'h00;
    file_load_o <= 1'b0;
    order_delete_o <= 1'b0;
    order_start_o <= 1'b0;
    loaded_reg <= 6'h00;
  end else begin
    in_prev_reg <= in_sync;
    // history is zero outside file-select, so entering it may load
    sel_prev_reg <= file_mode ? sel_num : 6'h00;
    sel_pend_reg <= sel_req && !service_reg; // R7
    print_start_o <= ev_start; // R2
    error_reset_o <= ev_err; // R2
    counter_reset_o <= ev_cnt; // R2
    release_o <= ev_rel; // R2
    file_num_o <= file_mode ? sel_num : 6'h00; // R6
    file_load_o <= sel_take && !service_reg; // R9
    order_delete_o <= sel_take && !service_reg; // R9
    // new order follows the load by one cycle
    order_start_o <= file_load_o; // R9
    if (sel_take && !service_reg) begin
      loaded_reg <= sel_num;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// output mapping

reg [7:0] map_next;

always @* begin
  map_next = 8'h00;
  case (prof_reg)
    `IOPM_PROF_STANDARD_B: begin
      map_next = {st_ribbon_warn_i, st_print_pos_i, st_head_down_i, st_returning_i,
        st_printing_i, st_cassette_open_i, st_ready_i, st_error_i}; // R4
    end
    `IOPM_PROF_REDUCED: begin
      map_next = {st_ribbon_warn_i, st_returning_i, st_error_i, st_ready_i,
        3'b000, st_ready_i}; // R11
    end
    `IOPM_PROF_LEGACY: begin
      map_next = {st_ribbon_warn_i, st_returning_i, st_head_down_i, st_ready_i,
        st_printing_i, st_generating_i, st_order_i, st_error_i}; // R12
    end
    default: begin
      // standard and file-select share the output side
      map_next = {st_ribbon_warn_i, st_returning_i, st_error_i, st_ready_i,
        st_printing_i, st_generating_i, st_order_i, st_error_i}; // R2 R5
    end
  endcase
end

// ready is taken from the controller which already folds in layout time
genvar gp;
generate
  for (gp = 0; gp < 8; gp = gp + 1) begin : g_out
    always @(posedge mclk_i) begin
      if (!rst_n_i) begin
        out_port_o[gp] <= 1'b0;
      end else begin
        out_port_o[gp] <= service_reg ? force_reg[gp] : map_next[gp]; // R1 R14 R15
      end
    end
  end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// register file and interrupts

wire [`IOPM_IRQ_W-1:0] irq_ev;
assign irq_ev[`IOPM_IRQ_START] = ev_start;
assign irq_ev[`IOPM_IRQ_ERR_RST] = ev_err;
assign irq_ev[`IOPM_IRQ_CNT_RST] = ev_cnt;
assign irq_ev[`IOPM_IRQ_LOAD] = sel_take && !service_reg;
assign irq_ev[`IOPM_IRQ_REJECT] = sel_reject && !service_reg;

// write strobe aimed at one register word
function wr_hit;
  input wr;
  input [3:0] addr;
  input [3:0] target;
  begin
    wr_hit = wr && (addr == target);
  end
endfunction

wire wr_ctrl = wr_hit(reg_wr_i, reg_addr_i, `IOPM_ADDR_CTRL);
wire wr_clr = wr_hit(reg_wr_i, reg_addr_i, `IOPM_ADDR_IRQ_CLR);
wire wr_force = wr_hit(reg_wr_i, reg_addr_i, `IOPM_ADDR_FORCE_VAL);
wire wr_en = wr_hit(reg_wr_i, reg_addr_i, `IOPM_ADDR_IRQ_EN);
wire [`IOPM_IRQ_W-1:0] clr_bits = wr_clr ? reg_wdata_i[`IOPM_IRQ_W-1:0] : 5'h00;
// set wins over a clear in the same cycle
wire [`IOPM_IRQ_W-1:0] stat_next = (irq_stat_reg & ~clr_bits) | irq_ev;

// one sticky flop per event
genvar gs;
generate
  for (gs = 0; gs < `IOPM_IRQ_W; gs = gs + 1) begin : g_stat
    always @(posedge mclk_i) begin
      if (!rst_n_i) begin
        irq_stat_reg[gs] <= 1'b0;
      end else begin
        irq_stat_reg[gs] <= stat_next[gs];
      end
    end
  end
endgenerate

always @(posedge mclk_i) begin
  if (!rst_n_i) begin
    prof_reg <= `IOPM_PROF_STANDARD;
    service_reg <= 1'b0;
    force_reg <= 8'h00;
    irq_en_reg <= 5'h00;
    irq_o <= 1'b0;
  end else begin
    // unknown profile codes are refused, keeping the last good one
    if (wr_ctrl && is_prof(reg_wdata_i[`IOPM_CTRL_PROF_MSB:`IOPM_CTRL_PROF_LSB])) begin
      prof_reg <= reg_wdata_i[`IOPM_CTRL_PROF_MSB:`IOPM_CTRL_PROF_LSB]; // R1
    end
    if (wr_ctrl) begin
      service_reg <= reg_wdata_i[`IOPM_CTRL_SERVICE];
    end
    // force values persist across service exits
    if (wr_force) begin
      force_reg <= reg_wdata_i[7:0]; // R14
    end
    if (wr_en) begin
      irq_en_reg <= reg_wdata_i[`IOPM_IRQ_W-1:0];
    end
    // level follows the next status so it rises with the sticky bit
    irq_o <= |(stat_next & irq_en_reg);
  end
end

always @(posedge mclk_i) begin
  if (!rst_n_i) begin
    reg_rdata_o <= 16'h0000;
  end else if (reg_rd_i) begin
    case (reg_addr_i)
      `IOPM_ADDR_CTRL: reg_rdata_o <= {12'h000, service_reg, prof_reg};
      `IOPM_ADDR_STATUS: reg_rdata_o <= {8'h00, out_port_o};
      // raw synchronised levels, visible in every mode
      `IOPM_ADDR_INPUTS: reg_rdata_o <= {8'h00, in_sync}; // R13
      `IOPM_ADDR_FORCE_VAL: reg_rdata_o <= {8'h00, force_reg};
      `IOPM_ADDR_IRQ_STAT: reg_rdata_o <= {11'h000, irq_stat_reg};
      `IOPM_ADDR_IRQ_EN: reg_rdata_o <= {11'h000, irq_en_reg};
      `IOPM_ADDR_LOADED: reg_rdata_o <= {10'h000, loaded_reg};
      default: reg_rdata_o <= 16'h0000;
    endcase
  end else begin
    // data stand one cycle only, so a late sampler sees zero
    reg_rdata_o <= 16'h0000;
  end
end

endmodule // iopm_port_mapper

//--- rtl/iopm_defs.vh
`ifndef IOPM_DEFS_VH
`define IOPM_DEFS_VH

// register word addresses
`define IOPM_ADDR_CTRL 4'h0
`define IOPM_ADDR_STATUS 4'h1
`define IOPM_ADDR_INPUTS 4'h2
`define IOPM_ADDR_FORCE_VAL 4'h3
`define IOPM_ADDR_IRQ_STAT 4'h4
`define IOPM_ADDR_IRQ_CLR 4'h5
`define IOPM_ADDR_IRQ_EN 4'h6
`define IOPM_ADDR_LOADED 4'h7

// ctrl fields
`define IOPM_CTRL_PROF_LSB 0
`define IOPM_CTRL_PROF_MSB 2
`define IOPM_CTRL_SERVICE 3
`define IOPM_CTRL_RESET 16'h0000

// profile codes
`define IOPM_PROF_STANDARD 3'h0
`define IOPM_PROF_STANDARD_B 3'h1
`define IOPM_PROF_FILE_SELECT 3'h2
`define IOPM_PROF_REDUCED 3'h3
`define IOPM_PROF_LEGACY 3'h4

// printer states seen on prn_state_i
`define IOPM_PST_READY 2'h0
`define IOPM_PST_WAITING 2'h1
`define IOPM_PST_STOP 2'h2
`define IOPM_PST_BUSY 2'h3

// irq bits
`define IOPM_IRQ_START 0
`define IOPM_IRQ_ERR_RST 1
`define IOPM_IRQ_CNT_RST 2
`define IOPM_IRQ_LOAD 3
`define IOPM_IRQ_REJECT 4
`define IOPM_IRQ_W 5

`endif

//--- rtl/iopm_sync.v
`timescale 1ns/10ps
// two-stage synchroniser for the opto input ports
module iopm_sync (
  // clock and reset
  input wire mclk_i,
  input wire rst_n_i,
  // asynchronous levels in, synchronous levels out
  input wire [7:0] async_i,
  output reg [7:0] sync_o
);

reg [7:0] meta_reg;

genvar g;
generate
  for (g = 0; g < 8; g = g + 1) begin : g_bit
    always @(posedge mclk_i) begin
      if (!rst_n_i) begin
        meta_reg[g] <= 1'b0;
        sync_o[g] <= 1'b0;
      end else begin
        meta_reg[g] <= async_i[g];
        sync_o[g] <= meta_reg[g];
      end
    end
  end
endgenerate

endmodule // iopm_sync

//--- bench/iopm_mach.sv
`timescale 1ns/10ps
// machine side: switches feed the opto inputs, a closed switch drives high
module iopm_mach (
  // switch levels
  input wire [7:0] sw_i,
  // opto input ports
  output wire [7:0] port_o
);
  assign port_o = sw_i;
endmodule // iopm_mach

//--- bench/iopm_port_mapper_sva.sv
`timescale 1ns/10ps
module iopm_chk (
  input wire mclk_i,
  input wire rst_n_i,
  input wire [3:0] reg_addr_i,
  input wire [15:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [15:0] reg_rdata_o,
  input wire [1:0] prn_state_i,
  input wire st_returning_i,
  input wire st_at_start_i,
  input wire st_ribbon_warn_i,
  input wire [7:0] out_port_o,
  input wire print_start_o,
  input wire release_o,
  input wire [5:0] file_num_o,
  input wire file_load_o,
  input wire order_delete_o,
  input wire order_start_o
);
  reg svc_reg;
  reg [2:0] prof_reg;
  // ctrl mirror; bad profile codes keep the old profile
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      svc_reg <= 1'b0;
      prof_reg <= 3'h0;
    end else if (reg_wr_i && reg_addr_i == 4'h0) begin
      svc_reg <= reg_wdata_i[3];
      if (reg_wdata_i[2:0] <= 3'h4) prof_reg <= reg_wdata_i[2:0];
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////
  chk_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0000)
    else $error("read data outside read slot");
  chk_load_start: assert property (file_load_o |=> order_start_o)
    else $error("load without order start");
  chk_load_delete: assert property (file_load_o == order_delete_o)
    else $error("load and delete apart");
  chk_load_nonzero: assert property (file_load_o |-> file_num_o != 6'h00 && prof_reg == 3'h2)
    else $error("load with zero number");
  chk_load_state: assert property (file_load_o |-> $past(prn_state_i) != 2'h3)
    else $error("load while busy");
  chk_start_width: assert property (print_start_o |=> !print_start_o)
    else $error("start pulse too long");
  chk_start_gate: assert property (print_start_o |-> $past(st_at_start_i) && !$past(st_returning_i))
    else $error("start away from start position");
  chk_ribbon_port: assert property (!svc_reg && !$past(svc_reg)
    |-> out_port_o[7] == $past(st_ribbon_warn_i))
    else $error("port 16 not ribbon warning");
  chk_reduced_unused: assert property (prof_reg == 3'h3 && $past(prof_reg) == 3'h3 && !svc_reg
    && !$past(svc_reg) |-> out_port_o[3:1] == 3'h0)
    else $error("reduced ports 10-12 not low");
  chk_release_prof: assert property (release_o
    |-> $past(prof_reg) <= 3'h1 && !$past(svc_reg))
    else $error("release outside standard profiles");
  cover property (file_load_o);
  cover property (print_start_o);
  cover property (svc_reg && out_port_o != 8'h00);
endmodule // iopm_chk
bind iopm_port_mapper iopm_chk u_chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .prn_state_i(prn_state_i), .st_returning_i(st_returning_i),
  .st_at_start_i(st_at_start_i), .st_ribbon_warn_i(st_ribbon_warn_i), .out_port_o(out_port_o),
  .print_start_o(print_start_o), .file_num_o(file_num_o), .file_load_o(file_load_o),
  .release_o(release_o),
  .order_delete_o(order_delete_o), .order_start_o(order_start_o));

//--- bench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  reg mclk_i = 0;
  reg rst_n_i = 0;
  reg [3:0] addr = 0;
  reg [15:0] wdat = 0;
  reg wr_s = 0;
  reg rd_s = 0;
  reg [7:0] sw = 0;
  reg [1:0] pst = 0;
  reg [10:0] st = 0;
  reg [10:0] stv;
  reg found = 1;
  wire [15:0] rdat;
  wire [7:0] inp;
  wire [7:0] outp;
  wire [5:0] fnum;
  wire p_st, p_er, p_cr, p_ld, p_rl, irq;
  reg [15:0] n_st = 0, n_er = 0, n_cr = 0, n_ld = 0, n_rl = 0;
  reg [15:0] d;
  integer err_total = 0;
  integer n_compared = 0;
  integer p, k;
  iopm_mach u_mach (.sw_i(sw), .port_o(inp));
  iopm_port_mapper DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr),
    .reg_wdata_i(wdat), .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdat), .in_port_i(inp),
    .prn_state_i(pst), .st_error_i(st[0]), .st_order_i(st[1]), .st_generating_i(st[2]),
    .st_printing_i(st[3]), .st_ready_i(st[4]), .st_returning_i(st[5]), .st_at_start_i(st[6]),
    .st_cassette_open_i(st[7]), .st_head_down_i(st[8]), .st_print_pos_i(st[9]),
    .st_ribbon_warn_i(st[10]), .file_found_i(found), .out_port_o(outp), .print_start_o(p_st),
    .error_reset_o(p_er), .counter_reset_o(p_cr), .release_o(p_rl), .file_num_o(fnum),
    .file_load_o(p_ld), .order_delete_o(), .order_start_o(), .irq_o(irq));
  initial begin
    forever #50 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    n_st <= n_st + p_st;
    n_er <= n_er + p_er;
    n_cr <= n_cr + p_cr;
    n_ld <= n_ld + p_ld;
    n_rl <= n_rl + p_rl;
  end
  ////////////////////////////////////////
  function [7:0] exp_out(input [2:0] f, input [10:0] s);
    case (f)
      3'h1: exp_out = {s[10], s[9], s[8], s[5], s[3], s[7], s[4], s[0]};
      3'h3: exp_out = {s[10], s[5], s[0], s[4], 3'b000, s[4]};
      3'h4: exp_out = {s[10], s[5], s[8], s[4], s[3], s[2], s[1], s[0]};
      default: exp_out = {s[10], s[5], s[0], s[4], s[3], s[2], s[1], s[0]};
    endcase
  endfunction
  task wr(input [3:0] a, input [15:0] v);
    @(posedge mclk_i);
    addr <= a;
    wdat <= v;
    wr_s <= 1'b1;
    @(posedge mclk_i);
    wr_s <= 1'b0;
  endtask
  task rd(input [3:0] a, output [15:0] v);
    @(posedge mclk_i);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge mclk_i);
    rd_s <= 1'b0;
    #1 v = rdat;
  endtask
  // inputs pass two sync flops, so hold long enough to be seen
  task pulse(input [7:0] v);
    sw <= v;
    repeat (6) @(posedge mclk_i);
    sw <= 8'h00;
    repeat (6) @(posedge mclk_i);
  endtask
  task chk(input string nm, input [15:0] e, input [15:0] g);
    n_compared = n_compared + 1;
    if (g !== e) begin
      err_total = err_total + 1;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task print_verdict;
    $display("compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge mclk_i);
    err_total = err_total + 1;
    print_verdict;
  end
  initial begin
    repeat (3) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    rd(4'h0, d);
    chk("ctrl", 16'h0000, d);
    sw <= 8'hA5;
    repeat (4) @(posedge mclk_i);
    rd(4'h2, d);
    chk("inputs", 16'h00A5, d);
    sw <= 8'h00;
    for (p = 0; p < 5; p = p + 1) begin
      for (k = 0; k < 2; k = k + 1) begin
        stv = k ? 11'h5A5 : 11'h2DA;
        wr(4'h0, p[15:0]);
        st <= stv;
        repeat (3) @(posedge mclk_i);
        rd(4'h1, d);
        chk("status", {8'h00, exp_out(p[2:0], stv)}, d);
      end
    end
    wr(4'h0, 16'h0007);
    rd(4'h0, d);
    chk("ctrl", 16'h0004, d);
    wr(4'h0, 16'h0008);
    wr(4'h3, 16'h003C);
    repeat (2) @(posedge mclk_i);
    chk("forced", 16'h003C, {8'h00, outp});
    wr(4'h0, 16'h0000);
    st <= 11'h040;
    pulse(8'h01);
    chk("starts", 16'h0001, n_st);
    st <= 11'h060;
    pulse(8'h01);
    chk("starts", 16'h0001, n_st);
    pulse(8'h02);
    pulse(8'h04);
    pulse(8'hF0);
    // the A5 pattern at the start raised port 3 as well
    chk("resets", 16'h0102, {n_er[7:0], n_cr[7:0]});
    pulse(8'h08);
    chk("releases", 16'h0001, n_rl);
    wr(4'h0, 16'h0003);
    pulse(8'h08);
    chk("releases", 16'h0001, n_rl);
    wr(4'h5, 16'h001F);
    wr(4'h0, 16'h0002);
    wr(4'h6, 16'h0018);
    pulse({6'd37, 2'b00});
    chk("file_num", 16'h0000, {10'h000, fnum});
    chk("loads", 16'h0001, n_ld);
    rd(4'h7, d);
    chk("loaded", 16'h0025, d);
    pst <= 2'h3;
    pulse({6'd5, 2'b00});
    chk("loads", 16'h0001, n_ld);
    rd(4'h4, d);
    chk("irq_stat", 16'h0018, d);
    chk("irq", 16'h0001, {15'h0000, irq});
    wr(4'h6, 16'h0000);
    repeat (2) @(posedge mclk_i);
    chk("irq", 16'h0000, {15'h0000, irq});
    wr(4'h5, 16'h001F);
    rd(4'h4, d);
    chk("irq_stat", 16'h0000, d);
    pst <= 2'h2;
    found <= 1'b0;
    pulse({6'd9, 2'b00});
    chk("loads", 16'h0001, n_ld);
    found <= 1'b1;
    sw <= {6'd9, 2'b00};
    repeat (6) @(posedge mclk_i);
    chk("file_num", 16'h0009, {10'h000, fnum});
    sw <= 8'h00;
    repeat (6) @(posedge mclk_i);
    chk("loads", 16'h0002, n_ld);
    rd(4'hF, d);
    chk("unmapped", 16'h0000, d);
    print_verdict;
  end
endmodule // tb_top
